// ===== rtl/shp_pkg.sv
package shp_pkg;
    // Clock and line rate
    localparam int unsigned CLK_HZ        = 20_000_000;
    localparam int unsigned BAUD          = 9600;
    localparam int unsigned OVERSAMPLE    = 16;
    localparam int unsigned TICK_DIV      = CLK_HZ / (BAUD * OVERSAMPLE);
    localparam int unsigned DATA_BITS     = 8;
    localparam int unsigned HALF_BIT_TICK = OVERSAMPLE / 2;

    // Register indices
    localparam logic [3:0] ADR_CTRL    = 4'h0;
    localparam logic [3:0] ADR_STATUS  = 4'h1;
    localparam logic [3:0] ADR_IRQ_ST  = 4'h2;
    localparam logic [3:0] ADR_IRQ_MSK = 4'h3;
    localparam logic [3:0] ADR_TXDATA  = 4'h4;
    localparam logic [3:0] ADR_RXDATA  = 4'h5;

    // Control register fields
    localparam int unsigned CTRL_PAR_LO  = 0;
    localparam int unsigned CTRL_PAR_HI  = 1;
    localparam int unsigned CTRL_SRQ     = 2;
    localparam int unsigned CTRL_IN_OVL  = 3;
    localparam int unsigned CTRL_OUT_OVL = 4;
    localparam logic [7:0]  CTRL_RESET   = 8'h00;

    // Event bits, shared by irq status and mask
    localparam int unsigned EV_RX_DONE  = 0;
    localparam int unsigned EV_TX_DONE  = 1;
    localparam int unsigned EV_FRAME    = 2;
    localparam int unsigned EV_PARITY   = 3;
    localparam int unsigned EV_OVERRUN  = 4;
    localparam int unsigned EV_BITS     = 5;
    localparam logic [7:0]  MSK_RESET   = 8'h00;

    // Parity modes
    typedef enum logic [1:0] {
        SHP_PAR_NONE = 2'h0,
        SHP_PAR_ODD  = 2'h1,
        SHP_PAR_EVEN = 2'h2,
        SHP_PAR_MARK = 2'h3
    } shp_par_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } shp_bus_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
        logic       frame_err;
        logic       par_err;
    } shp_rx_t;
endpackage : shp_pkg

// ===== rtl/shp_rx.sv
`timescale 1ns/10ps
`default_nettype none
module shp_rx
    import shp_pkg::*;
(
    // Clock and reset
    input  wire logic     clk,
    input  wire logic     rst_n,
    // Line, logic level, synchronised
    input  wire logic     line,
    input  wire logic     tick,
    input  wire shp_par_t par_mode,
    // Received character
    output var shp_rx_t   rx
);
    typedef enum {SHP_RX_IDLE, SHP_RX_START, SHP_RX_DATA,
                  SHP_RX_PAR, SHP_RX_STOP} shp_rx_st_t;

    shp_rx_st_t st_q;
    logic [3:0] os_q;
    logic [2:0] bit_q;
    logic [7:0] sh_q;
    logic       par_q;
    logic       perr_q;
    shp_rx_t    rx_q;

    wire        mid       = (os_q == 4'(HALF_BIT_TICK - 1));
    wire        full      = (os_q == 4'(OVERSAMPLE - 1));
    wire        last_bit  = (bit_q == 3'(DATA_BITS - 1));
    wire        par_exp   = (par_mode == SHP_PAR_ODD)  ? ~par_q :
                            (par_mode == SHP_PAR_EVEN) ?  par_q : 1'b1;

    assign rx = rx_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q   <= SHP_RX_IDLE;
            os_q   <= 4'h0;
            bit_q  <= 3'h0;
            sh_q   <= 8'h00;
            par_q  <= 1'b0;
            perr_q <= 1'b0;
            rx_q   <= '0;
        end else begin
            rx_q.valid <= 1'b0;
            if (tick) begin
                os_q <= os_q + 4'h1;
                unique case (st_q)
                    SHP_RX_IDLE: begin
                        os_q <= 4'h0;
                        if (!line) begin
                            st_q <= SHP_RX_START;
                        end
                    end
                    SHP_RX_START: begin
                        // Glitch shorter than half a bit is dropped
                        if (mid) begin
                            os_q  <= 4'h0;
                            bit_q <= 3'h0;
                            par_q <= 1'b0;
                            st_q  <= line ? SHP_RX_IDLE : SHP_RX_DATA;
                        end
                    end
                    SHP_RX_DATA: begin
                        if (full) begin
                            sh_q  <= {line, sh_q[7:1]};
                            par_q <= par_q ^ line;
                            bit_q <= bit_q + 3'h1;
                            if (last_bit) begin
                                st_q <= (par_mode == SHP_PAR_NONE) ?
                                        SHP_RX_STOP : SHP_RX_PAR;
                            end
                        end
                    end
                    SHP_RX_PAR: begin
                        if (full) begin
                            perr_q <= (line != par_exp);
                            st_q   <= SHP_RX_STOP;
                        end
                    end
                    SHP_RX_STOP: begin
                        if (full) begin
                            rx_q.valid     <= 1'b1;
                            rx_q.data      <= sh_q;
                            rx_q.frame_err <= ~line;
                            rx_q.par_err   <= perr_q;
                            perr_q         <= 1'b0;
                            st_q           <= SHP_RX_IDLE;
                        end
                    end
                endcase
            end
        end
    end
endmodule : shp_rx
`default_nettype wire

// ===== rtl/shp_tx.sv
`timescale 1ns/10ps
`default_nettype none
module shp_tx
    import shp_pkg::*;
(
    // Clock and reset
    input  wire logic     clk,
    input  wire logic     rst_n,
    // Character in
    input  wire logic     start,
    input  wire logic [7:0] data,
    input  wire logic     tick,
    input  wire shp_par_t par_mode,
    // Line, logic level
    output logic          line,
    output logic          busy,
    output logic          done
);
    typedef enum {SHP_TX_IDLE, SHP_TX_SEND} shp_tx_st_t;

    shp_tx_st_t  st_q;
    logic [3:0]  os_q;
    logic [3:0]  left_q;
    logic [10:0] sh_q;
    // Frame waits for a tick so every bit, the start bit too, is whole
    logic        go_q;

    wire par_even = ^data;
    wire par_bit  = (par_mode == SHP_PAR_ODD)  ? ~par_even :
                    (par_mode == SHP_PAR_EVEN) ?  par_even : 1'b1;
    wire with_par = (par_mode != SHP_PAR_NONE);
    // Frame is start, data, optional parity, stop
    wire [10:0] frame_p = {1'b1, par_bit, data, 1'b0};
    wire [10:0] frame_n = {1'b1, 1'b1, data, 1'b0};
    wire        bit_end = tick && (os_q == 4'(OVERSAMPLE - 1));

    assign busy = (st_q == SHP_TX_SEND) || go_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q   <= SHP_TX_IDLE;
            os_q   <= 4'h0;
            left_q <= 4'h0;
            sh_q   <= 11'h7FF;
            line   <= 1'b1;
            done   <= 1'b0;
            go_q   <= 1'b0;
        end else begin
            done <= 1'b0;
            unique case (st_q)
                SHP_TX_IDLE: begin
                    line <= 1'b1;
                    // Sent at the next tick, no handshake consulted
                    if (start) begin
                        sh_q   <= with_par ? frame_p : frame_n;
                        left_q <= with_par ? 4'hB : 4'hA;
                        go_q   <= 1'b1;
                    end
                    if (go_q && tick) begin
                        os_q <= 4'h0;
                        go_q <= 1'b0;
                        st_q <= SHP_TX_SEND;
                    end
                end
                SHP_TX_SEND: begin
                    line <= sh_q[0];
                    if (tick) begin
                        os_q <= os_q + 4'h1;
                    end
                    if (bit_end) begin
                        sh_q   <= {1'b1, sh_q[10:1]};
                        left_q <= left_q - 4'h1;
                        if (left_q == 4'h1) begin
                            st_q <= SHP_TX_IDLE;
                            done <= 1'b1;
                        end
                    end
                end
            endcase
        end
    end
endmodule : shp_tx
`default_nettype wire

// ===== rtl/shp_top.sv
// Strobed register access and the address map were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module shp_top
    import shp_pkg::*;
#(
    parameter int unsigned DIV = TICK_DIV
)(
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       arst_n,
    // Register port
    input  wire shp_pkg::shp_bus_t bus,
    output logic [7:0]      rdata,
    // Serial pins, inverted levels
    input  wire logic       txd_pin,
    output logic            rxd_pin,
    // Handshake and reference pins
    input  wire logic       rts_pin,
    output logic            cts_pin,
    input  wire logic       ref_clock_pos,
    input  wire logic       ref_clock_neg,
    // Status request, active low
    output logic            status_n,
    // Interrupt
    output logic            irq
);
    import shp_pkg::*;

    logic [1:0]  rst_sync_q;
    logic        rst_n;
    logic [2:0]  pin_q;
    logic        line_q;
    logic [15:0] div_q;
    logic        tick_q;
    logic [7:0]  ctrl_q;
    logic [7:0]  msk_q;
    logic [EV_BITS-1:0] ist_q;
    logic [7:0]  rxbuf_q;
    logic        rxfull_q;
    logic        txstart_q;
    logic [7:0]  txdata_q;
    shp_rx_t     rx;
    logic        tx_line;
    logic        tx_busy;
    logic        tx_done;
    logic        unused;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // Oversample tick from the own clock; reference pins are not used
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            div_q  <= 16'h0000;
            tick_q <= 1'b0;
        end else begin
            tick_q <= (div_q == 16'(DIV - 1));
            div_q  <= (div_q == 16'(DIV - 1)) ? 16'h0000 : div_q + 16'h0001;
        end
    end

    // Three-stage sync; change accepted when stages 2 and 3 agree
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pin_q  <= 3'h0;
            line_q <= 1'b1;
        end else begin
            pin_q <= {pin_q[1:0], txd_pin};
            if (pin_q[2] == pin_q[1]) begin
                line_q <= ~pin_q[2];
            end
        end
    end

    // Handshake and reference pins go nowhere
    assign unused = rts_pin ^ ref_clock_pos ^ ref_clock_neg;

    wire wr_ctrl = bus.wr && (bus.addr == ADR_CTRL);
    wire wr_ist  = bus.wr && (bus.addr == ADR_IRQ_ST);
    wire wr_msk  = bus.wr && (bus.addr == ADR_IRQ_MSK);
    wire wr_tx   = bus.wr && (bus.addr == ADR_TXDATA) && !tx_busy;
    wire rd_rx   = bus.rd && (bus.addr == ADR_RXDATA);
    wire shp_par_t par_mode = shp_par_t'(ctrl_q[CTRL_PAR_HI:CTRL_PAR_LO]);

    wire [EV_BITS-1:0] ev_set;
    assign ev_set[EV_RX_DONE] = rx.valid;
    assign ev_set[EV_TX_DONE] = tx_done;
    assign ev_set[EV_FRAME]   = rx.valid && rx.frame_err;
    assign ev_set[EV_PARITY]  = rx.valid && rx.par_err;
    assign ev_set[EV_OVERRUN] = rx.valid && rxfull_q && !rd_rx;

    wire [EV_BITS-1:0] ist_d = (ist_q & ~(wr_ist ? bus.wdata[EV_BITS-1:0]
                                : '0)) | ev_set;

    // Request from software or from overload
    wire srq = ctrl_q[CTRL_SRQ] | ctrl_q[CTRL_IN_OVL] | ctrl_q[CTRL_OUT_OVL];

    wire [7:0] status_w = {5'h00, tx_busy, rxfull_q, ~srq};
    wire [7:0] rd_mux =
        (bus.addr == ADR_CTRL)    ? ctrl_q :
        (bus.addr == ADR_STATUS)  ? status_w :
        (bus.addr == ADR_IRQ_ST)  ? {3'h0, ist_q} :
        (bus.addr == ADR_IRQ_MSK) ? msk_q :
        (bus.addr == ADR_RXDATA)  ? rxbuf_q : 8'h00;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= CTRL_RESET;
            msk_q  <= MSK_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= bus.wdata;
            end
            if (wr_msk) begin
                msk_q <= bus.wdata;
            end
        end
    end

    // Set wins over a write-one clear in the same cycle
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ist_q <= '0;
        end else begin
            ist_q <= ist_d;
        end
    end

    // Receive holding byte, taken without any flow control
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rxbuf_q  <= 8'h00;
            rxfull_q <= 1'b0;
        end else begin
            if (rx.valid) begin
                rxbuf_q  <= rx.data;
                rxfull_q <= 1'b1;
            end else if (rd_rx) begin
                rxfull_q <= 1'b0;
            end
        end
    end

    // A write while busy is dropped; software polls tx busy first
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            txstart_q <= 1'b0;
            txdata_q  <= 8'h00;
        end else begin
            txstart_q <= wr_tx;
            if (wr_tx) begin
                txdata_q <= bus.wdata;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdata    <= 8'h00;
            rxd_pin  <= 1'b0;
            cts_pin  <= 1'b0;
            status_n <= 1'b1;
            irq      <= 1'b0;
        end else begin
            rdata    <= bus.rd ? rd_mux : 8'h00;
            rxd_pin  <= ~tx_line;
            cts_pin  <= 1'b0;
            status_n <= ~srq;
            irq      <= |(ist_d & msk_q[EV_BITS-1:0]);
        end
    end

    shp_rx u_rx (
        .clk      (mclk),
        .rst_n    (rst_n),
        .line     (line_q),
        .tick     (tick_q),
        .par_mode (par_mode),
        .rx       (rx)
    );

    shp_tx u_tx (
        .clk      (mclk),
        .rst_n    (rst_n),
        .start    (txstart_q),
        .data     (txdata_q),
        .tick     (tick_q),
        .par_mode (par_mode),
        .line     (tx_line),
        .busy     (tx_busy),
        .done     (tx_done)
    );
endmodule : shp_top
`default_nettype wire

// ===== verification/shp_props.sv
`timescale 1ns/10ps
`default_nettype none
module shp_props
    import shp_pkg::*;
#(
    parameter int unsigned DIV = TICK_DIV
)(
    // Clock and reset
    input wire logic       mclk,
    input wire logic       arst_n,
    // Register port
    input wire shp_bus_t   bus,
    input wire logic [7:0] rdata,
    // Pins
    input wire logic       txd_pin,
    input wire logic       rxd_pin,
    input wire logic       rts_pin,
    input wire logic       cts_pin,
    input wire logic       ref_clock_pos,
    input wire logic       ref_clock_neg,
    input wire logic       status_n,
    input wire logic       irq
);
    localparam int BITC  = 16 * DIV;
    // Longer than any run of low bits inside a frame, so the line is idle
    localparam int QUIET = 12 * BITC;
    // Write, start pulse, wait for a tick, then two register stages
    localparam int LAUNCH = DIV + 5;
    int  hi_q;
    int  lo_q;
    wire wr_ctrl = bus.wr && bus.addr == ADR_CTRL;
    wire wr_tx   = bus.wr && bus.addr == ADR_TXDATA;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            hi_q <= 0;
            lo_q <= 0;
        end else begin
            hi_q <= rxd_pin ? hi_q + 1 : 0;
            lo_q <= rxd_pin ? 0 : (lo_q < QUIET ? lo_q + 1 : lo_q);
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    a_cts_unused: assert property (cts_pin == 1'b0)
        else $error("cts pin driven high");
    a_rdata_idle: assert property (!$past(bus.rd) |-> rdata == 8'h00)
        else $error("read data not zero outside read answer");
    a_rd_unmapped: assert property (
        bus.rd && bus.addr > ADR_RXDATA |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    a_srq_assert: assert property (
        wr_ctrl && bus.wdata[4:2] != 3'h0 |-> ##[1:2] !status_n)
        else $error("request line not asserted");
    a_srq_release: assert property (
        wr_ctrl && bus.wdata[4:2] == 3'h0 |-> ##[1:2] status_n)
        else $error("request line not released");
    a_irq_masked: assert property (
        bus.wr && bus.addr == ADR_IRQ_MSK && bus.wdata == 8'h00
        |-> ##2 !irq)
        else $error("irq high with all masked");
    a_tx_start: assert property (
        wr_tx && lo_q >= QUIET |-> ##[1:LAUNCH] rxd_pin [*8])
        else $error("start bit missing after write");
    a_bit_whole: assert property ($fell(rxd_pin) |-> hi_q % BITC == 0)
        else $error("high run not whole bit times");
    c_srq: cover property (!status_n);
    c_irq: cover property (irq);
    c_tx: cover property (wr_tx && lo_q >= QUIET);
endmodule : shp_props
bind shp_top shp_props #(.DIV(DIV)) u_props (
    .mclk(mclk), .arst_n(arst_n), .bus(bus), .rdata(rdata),
    .txd_pin(txd_pin), .rxd_pin(rxd_pin), .rts_pin(rts_pin),
    .cts_pin(cts_pin), .ref_clock_pos(ref_clock_pos),
    .ref_clock_neg(ref_clock_neg), .status_n(status_n), .irq(irq));
`default_nettype wire

// ===== verification/shp_far.sv
`timescale 1ns/10ps
`default_nettype none
module shp_far
    import shp_pkg::*;
#(
    parameter int unsigned DIV = TICK_DIV
)(
    // Clock
    input  wire logic clk,
    // Serial pins, inverted levels
    output var logic  txd_pin,
    input  wire logic rxd_pin
);
    localparam int BITC = 16 * DIV;
    shp_par_t   par     = SHP_PAR_NONE;
    logic [7:0] got;
    logic       gpar;
    logic       gstop;
    int         got_cnt = 0;
    initial txd_pin = 1'b0;
    function automatic logic pbit(logic [7:0] d, shp_par_t m);
        return m == SHP_PAR_ODD ? ~^d : m == SHP_PAR_EVEN ? ^d : 1'b1;
    endfunction : pbit
    // Faults only on request: flipped parity or a stop bit at logic zero
    task automatic send(logic [7:0] d, logic flip, logic bad_stop);
        logic [10:0] f;
        int          n;
        f = {~bad_stop, pbit(d, par) ^ flip, d, 1'b0};
        n = par == SHP_PAR_NONE ? 10 : 11;
        if (n == 10) f[9] = f[10];
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            txd_pin <= ~f[i];
            repeat (BITC - 1) @(posedge clk);
        end
        @(posedge clk);
        txd_pin <= 1'b0;
    endtask : send
    always begin
        @(posedge rxd_pin);
        repeat (BITC / 2) @(posedge clk);
        if (rxd_pin) begin
            for (int i = 0; i < 8; i++) begin
                repeat (BITC) @(posedge clk);
                got[i] = ~rxd_pin;
            end
            if (par != SHP_PAR_NONE) begin
                repeat (BITC) @(posedge clk);
                gpar = ~rxd_pin;
            end
            repeat (BITC) @(posedge clk);
            gstop = ~rxd_pin;
            got_cnt++;
        end
    end
endmodule : shp_far
`default_nettype wire

// ===== verification/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import shp_pkg::*;
    localparam int unsigned DIV = 4;
    logic     mclk = 1'b0;
    logic     arst_n;
    shp_bus_t bus;
    logic     rts_pin = 1'b0;
    logic     ref_pos = 1'b0;
    logic     ref_neg = 1'b1;
    logic [7:0] rdata;
    logic     rxd_pin, cts_pin, status_n, irq;
    wire logic txd_pin;
    int       err_count = 0;
    int       samples_checked = 0;
    int       cyc = 0;
    shp_top #(.DIV(DIV)) dut (.mclk(mclk), .arst_n(arst_n), .bus(bus),
        .rdata(rdata), .txd_pin(txd_pin), .rxd_pin(rxd_pin),
        .rts_pin(rts_pin), .cts_pin(cts_pin), .ref_clock_pos(ref_pos),
        .ref_clock_neg(ref_neg), .status_n(status_n), .irq(irq));
    shp_far #(.DIV(DIV)) far (.clk(mclk), .txd_pin(txd_pin),
        .rxd_pin(rxd_pin));
    always #25 mclk = ~mclk;
    // Handshake and reference pins keep moving; nothing may follow them
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        rts_pin <= cyc[5];
        ref_pos <= ~ref_pos;
        ref_neg <= ref_pos;
    end
    task automatic chk(logic [7:0] g, logic [7:0] e);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic wr(logic [3:0] a, logic [7:0] d);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge mclk);
        bus <= '0;
        @(posedge mclk);
    endtask : wr
    task automatic rd(logic [3:0] a, logic [7:0] m, logic [7:0] e);
        bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge mclk);
        bus <= '0;
        @(negedge mclk);
        chk(rdata & m, e);
        @(posedge mclk);
    endtask : rd
    task automatic wait_irq();
        for (int i = 0; i < 3000 && irq !== 1'b1; i++) @(posedge mclk);
        chk({7'h0, irq}, 8'h01);
    endtask : wait_irq
    task automatic report_and_stop();
        $display("errors=%0d checks=%0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : report_and_stop
    initial begin
        #2_000_000;
        err_count++;
        report_and_stop();
    end
    initial begin
        logic [7:0] d;
        int         n;
        arst_n = 1'b0;
        bus = '0;
        repeat (4) @(posedge mclk);
        arst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        rd(ADR_CTRL, 8'hFF, CTRL_RESET);
        rd(ADR_IRQ_MSK, 8'hFF, MSK_RESET);
        rd(ADR_STATUS, 8'h07, 8'h01);
        rd(4'hF, 8'hFF, 8'h00);
        chk({7'h0, status_n}, 8'h01);
        chk({7'h0, cts_pin}, 8'h00);
        for (int k = 2; k < 5; k++) begin
            wr(ADR_CTRL, 8'h01 << k);
            rd(ADR_STATUS, 8'h01, 8'h00);
            chk({7'h0, status_n}, 8'h00);
            wr(ADR_CTRL, 8'h00);
            rd(ADR_STATUS, 8'h01, 8'h01);
            chk({7'h0, status_n}, 8'h01);
        end
        // Transmit in every parity mode; a second write while busy is lost
        wr(ADR_IRQ_MSK, 8'h02);
        for (int m = 0; m < 4; m++) begin
            d = 8'hA5 ^ 8'(m * 33);
            wr(ADR_CTRL, 8'(m));
            far.par = shp_par_t'(m);
            wr(ADR_IRQ_ST, 8'h1F);
            n = far.got_cnt;
            wr(ADR_TXDATA, d);
            rd(ADR_STATUS, 8'h04, 8'h04);
            wr(ADR_TXDATA, 8'h00);
            wait_irq();
            chk(far.got, d);
            chk({7'h0, far.gstop}, 8'h01);
            if (m != 0) chk({7'h0, far.gpar},
                {7'h0, far.pbit(d, shp_par_t'(m))});
            rd(ADR_IRQ_ST, 8'h1F, 8'h02);
            wr(ADR_IRQ_ST, 8'h02);
            rd(ADR_STATUS, 8'h04, 8'h00);
            chk({7'h0, irq}, 8'h00);
            repeat (800) @(posedge mclk);
            chk(8'(far.got_cnt - n), 8'h01);
        end
        // Receive in every parity mode, then parity and framing faults
        wr(ADR_IRQ_MSK, 8'h01);
        for (int m = 0; m < 5; m++) begin
            d = 8'h3C + 8'(m * 45);
            wr(ADR_CTRL, m < 4 ? 8'(m) : 8'h01);
            far.par = shp_par_t'(m < 4 ? m : 1);
            wr(ADR_IRQ_ST, 8'h1F);
            far.send(d, m == 4, 1'b0);
            wait_irq();
            rd(ADR_STATUS, 8'h02, 8'h02);
            rd(ADR_RXDATA, 8'hFF, d);
            rd(ADR_STATUS, 8'h02, 8'h00);
            rd(ADR_IRQ_ST, 8'h0D, m == 4 ? 8'h09 : 8'h01);
        end
        wr(ADR_IRQ_ST, 8'h1F);
        far.send(8'h81, 1'b0, 1'b1);
        wait_irq();
        rd(ADR_IRQ_ST, 8'h04, 8'h04);
        wr(ADR_IRQ_MSK, 8'h00);
        rd(ADR_IRQ_MSK, 8'hFF, 8'h00);
        chk({7'h0, irq}, 8'h00);
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
